// File: rtl/vip_params.svh
// Constants of the vectored interrupt prioritizer: addresses, widths, offsets.
`ifndef VIP_PARAMS_SVH
`define VIP_PARAMS_SVH
`define VIP_NUM_IRQ        118
`define VIP_NUM_TRAP       8
`define VIP_IRQ_IDX_W      7
`define VIP_PRIO_W         3
`define VIP_LVL_W          4
`define VIP_ADDR_W         24
`define VIP_DATA_W         16
`define VIP_REG_AW         8
`define VIP_TRAP_BASE      24'h000004
`define VIP_IRQ_BASE       24'h000014
`define VIP_ALT_OFFSET     24'h000100
`define VIP_RESET_PC       24'h000000
`define VIP_CODE_START     24'h000200
`define VIP_PRIO_BLOCK     3'h7
`define VIP_PRIO_RESET     3'h4
`define VIP_TRAP_LVL_BIT   3
`define VIP_ALT_BIT        15
`define VIP_TRAP_MASK      8'h1E
`define VIP_NUM_FLAG_REGS  8
`define VIP_NUM_PRIO_REGS  30
`define VIP_PER_PRIO_REG   4
`define VIP_OFF_CTRL2      8'h00
`define VIP_OFF_STATUS     8'h01
`define VIP_OFF_FLAG       8'h10
`define VIP_OFF_ENABLE     8'h20
`define VIP_OFF_PRIO       8'h30
`define VIP_ENTRY_CYCLES   3'h3
`define VIP_EXIT_CYCLES    3'h3
`endif

// File: rtl/vip_pkg.sv
// Types shared by the vectored interrupt prioritizer.
package vip_pkg;
	typedef enum logic [1:0] {VIP_IDLE, VIP_ENTRY, VIP_SERVICE, VIP_RETURN}
		vip_state_t;
	typedef struct packed {
		logic        valid;
		logic        is_trap;
		logic [6:0]  vec_num;
		logic [3:0]  level;
	} vip_win_t;
	typedef struct packed {
		logic        req;
		logic [23:0] vec_addr;
		logic [6:0]  vec_num;
		logic [3:0]  level;
	} vip_core_req_t;
endpackage : vip_pkg

// File: rtl/vip_prioritizer.sv
// Vectored interrupt prioritizer: flags, enables, levels, vector fetch.
`timescale 1ns/1ps
`include "vip_params.svh"
////////////////////////////////////////////////////////////////////////////////
// Function
// - Merge all peripheral and pin requests into one core request output.
// - Eight traps precede interrupts; user priority never blocks them.
// - Each user source gets a software-set priority level used in arbitration.
// - Primary table starts at 000004h: 8 traps then 118 interrupt vectors.
// - Each vector entry is a 24-bit handler start address.
// - At equal conditions the lower table address wins; vector 0 beats all.
// - Equal user levels break ties by fixed order, never rotation.
// - Alternate-select bit 15 of control two redirects all vector fetches.
// - Alternate table mirrors primary layout at plus 100h, from 000104h.
// - Traps: 1 oscillator fail, 2 address, 3 stack, 4 math; others reserved.
// - Reset clears registers except priority fields, which reset to 4, and forces the program counter to zero.
// - Interrupt vector n sits at 000014h plus two times n.
// - Each source has its own distinct vector address.
// - Entry and return take fixed cycle counts for every source.
// - Tables end at 0001FEh; program code begins at 000200h.
// - Request flags set by hardware stay set until software clears them.
// - Flag, enable and priority banks are ordered by vector number.
// - Accepted request latches 7-bit vector number and 4-bit new level.
// - Processor level 111 holds off user interrupts but not traps.
module vip_prioritizer (
	input  wire logic                       clk,          // system clock
	input  wire logic                       rst,          // async reset
	input  wire logic [`VIP_NUM_IRQ-1:0]    irq_in,       // source set pulses
	input  wire logic [`VIP_NUM_TRAP-1:0]   trap_in,      // trap events
	input  wire logic [2:0]                 cpu_priority_level, // core level
	input  wire logic                       ack,          // core takes request
	input  wire logic                       ret,          // core returns
	input  wire logic [`VIP_REG_AW-1:0]     addr,         // register index
	input  wire logic [`VIP_DATA_W-1:0]     wdata,        // write data
	input  wire logic                       wr,           // write strobe
	input  wire logic                       rd,           // read strobe
	output logic [`VIP_DATA_W-1:0]          rdata,        // read data
	output vip_pkg::vip_core_req_t          core_req,     // request to core
	output logic                            busy,         // entry, service or return
	output logic [`VIP_ADDR_W-1:0]          pc_reset      // reset program ctr
);
	////////////////////////////////////////////////////////////////////////
	logic [`VIP_NUM_IRQ-1:0]      request_flag_bank_q;
	logic [`VIP_NUM_IRQ-1:0]      enable_bank_q;
	logic [`VIP_PRIO_W-1:0]       priority_field_bank_q [`VIP_NUM_IRQ];
	logic [`VIP_NUM_TRAP-1:0]     trap_flag_q;
	logic [`VIP_DATA_W-1:0]       interrupt_control_two_q;
	logic [6:0]                   latched_vector_number_q;
	logic [3:0]                   latched_new_level_q;
	vip_pkg::vip_state_t          state_q;
	logic [2:0]                   cnt_q;
	vip_pkg::vip_win_t            win;
	vip_pkg::vip_win_t            cur_q;
	logic [`VIP_NUM_IRQ-1:0]      flag_wr_mask;
	logic [`VIP_NUM_IRQ-1:0]      en_wr_mask;
	logic                         alt_table_select;
	logic [`VIP_ADDR_W-1:0]       vec_addr;

	assign alt_table_select = interrupt_control_two_q[`VIP_ALT_BIT];
	assign pc_reset = `VIP_RESET_PC;

	////////////////////////////////////////////////////////////////////////
	// Register write decode per source; bank slot follows vector order.
	genvar g;
	generate
		for (g = 0; g < `VIP_NUM_IRQ; g++) begin : g_src
			localparam int W = g / `VIP_DATA_W;
			localparam int B = g % `VIP_DATA_W;
			localparam int P = g / `VIP_PER_PRIO_REG;
			localparam int F = (g % `VIP_PER_PRIO_REG) * 4;
			assign flag_wr_mask[g] = wr && (addr ==
				`VIP_REG_AW'(`VIP_OFF_FLAG + W));
			assign en_wr_mask[g] = wr && (addr ==
				`VIP_REG_AW'(`VIP_OFF_ENABLE + W));
			// Hardware set wins over a software clear in the same cycle.
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					request_flag_bank_q[g] <= 1'b0;
				end else if (irq_in[g]) begin
					request_flag_bank_q[g] <= 1'b1;
				end else if (flag_wr_mask[g]) begin
					request_flag_bank_q[g] <= wdata[B];
				end else if (state_q == vip_pkg::VIP_ENTRY && cnt_q == 3'h0
					&& !cur_q.is_trap && cur_q.vec_num == 7'(g)) begin
					request_flag_bank_q[g] <= request_flag_bank_q[g];
				end
			end
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					enable_bank_q[g] <= 1'b0;
				end else if (en_wr_mask[g]) begin
					enable_bank_q[g] <= wdata[B];
				end
			end
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					priority_field_bank_q[g] <= `VIP_PRIO_RESET;
				end else if (wr && addr ==
					`VIP_REG_AW'(`VIP_OFF_PRIO + P)) begin
					priority_field_bank_q[g] <= wdata[F +: 3];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Trap flags: hardware sets, software clears via status write.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			trap_flag_q <= '0;
		end else begin
			trap_flag_q <= (trap_flag_q & ~(
				(wr && addr == `VIP_OFF_STATUS) ? wdata[7:0] : 8'h00))
				| (trap_in & `VIP_TRAP_MASK);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			interrupt_control_two_q <= '0;
		end else if (wr && addr == `VIP_OFF_CTRL2) begin
			interrupt_control_two_q <= wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Arbitration: traps first by lowest number, then highest user level,
	// ties broken by the lowest vector number.
	always_comb begin
		win = '0;
		for (int t = `VIP_NUM_TRAP - 1; t >= 0; t--) begin
			if (trap_flag_q[t]) begin
				win.valid   = 1'b1;
				win.is_trap = 1'b1;
				win.vec_num = 7'(t);
				win.level   = {1'b1, 3'h7};
			end
		end
		if (!win.valid && cpu_priority_level != `VIP_PRIO_BLOCK) begin
			for (int i = `VIP_NUM_IRQ - 1; i >= 0; i--) begin
				if (request_flag_bank_q[i] && enable_bank_q[i]
					&& priority_field_bank_q[i] > cpu_priority_level
					&& priority_field_bank_q[i] >= win.level[2:0]) begin
					win.valid   = 1'b1;
					win.vec_num = 7'(i);
					win.level   = {1'b0, priority_field_bank_q[i]};
				end
			end
		end
	end

	// Each source maps to its own two-byte slot in the chosen table.
	always_comb begin
		vec_addr = win.is_trap
			? `VIP_TRAP_BASE + {16'h0000, win.vec_num, 1'b0}
			: `VIP_IRQ_BASE + {16'h0000, win.vec_num, 1'b0};
		if (alt_table_select) begin
			vec_addr = vec_addr + `VIP_ALT_OFFSET;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Fixed-length entry and return sequences.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= vip_pkg::VIP_IDLE;
			cnt_q   <= '0;
			cur_q   <= '0;
		end else begin
			unique case (state_q)
				vip_pkg::VIP_IDLE: begin
					cur_q <= win;
					if (win.valid && ack) begin
						state_q <= vip_pkg::VIP_ENTRY;
						cnt_q   <= `VIP_ENTRY_CYCLES;
					end
				end
				vip_pkg::VIP_ENTRY: begin
					cnt_q <= cnt_q - 3'h1;
					if (cnt_q == 3'h1) begin
						state_q <= vip_pkg::VIP_SERVICE;
					end
				end
				vip_pkg::VIP_SERVICE: begin
					if (ret) begin
						state_q <= vip_pkg::VIP_RETURN;
						cnt_q   <= `VIP_EXIT_CYCLES;
					end
				end
				vip_pkg::VIP_RETURN: begin
					cnt_q <= cnt_q - 3'h1;
					if (cnt_q == 3'h1) begin
						state_q <= vip_pkg::VIP_IDLE;
					end
				end
			endcase
		end
	end

	// Latch vector number and level when the core accepts a request in idle.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			latched_vector_number_q <= '0;
			latched_new_level_q     <= '0;
		end else if (state_q == vip_pkg::VIP_IDLE && win.valid && ack) begin
			latched_vector_number_q <= win.is_trap ? win.vec_num
				: 7'(win.vec_num + 7'(`VIP_NUM_TRAP));
			latched_new_level_q     <= win.level;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			core_req <= '0;
		end else begin
			core_req.req      <= win.valid && state_q == vip_pkg::VIP_IDLE
				&& !ack;
			core_req.vec_addr <= vec_addr;
			core_req.vec_num  <= win.is_trap ? win.vec_num
				: 7'(win.vec_num + 7'(`VIP_NUM_TRAP));
			core_req.level    <= win.level;
		end
	end
	assign busy = state_q != vip_pkg::VIP_IDLE;

	////////////////////////////////////////////////////////////////////////
	// Register read port, data one cycle after the strobe.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata <= '0;
		end else if (rd) begin
			rdata <= '0;
			if (addr == `VIP_OFF_CTRL2) begin
				rdata <= interrupt_control_two_q;
			end else if (addr == `VIP_OFF_STATUS) begin
				rdata <= {1'b0, latched_new_level_q, latched_vector_number_q,
					4'h0} | {8'h00, trap_flag_q};
			end else if (addr >= `VIP_OFF_FLAG && addr <
				`VIP_REG_AW'(`VIP_OFF_FLAG + `VIP_NUM_FLAG_REGS)) begin
				for (int b = 0; b < `VIP_DATA_W; b++) begin
					if (int'(addr - `VIP_OFF_FLAG) * 16 + b < `VIP_NUM_IRQ)
						rdata[b] <= request_flag_bank_q[
							int'(addr - `VIP_OFF_FLAG) * 16 + b];
				end
			end else if (addr >= `VIP_OFF_ENABLE && addr <
				`VIP_REG_AW'(`VIP_OFF_ENABLE + `VIP_NUM_FLAG_REGS)) begin
				for (int b = 0; b < `VIP_DATA_W; b++) begin
					if (int'(addr - `VIP_OFF_ENABLE) * 16 + b < `VIP_NUM_IRQ)
						rdata[b] <= enable_bank_q[
							int'(addr - `VIP_OFF_ENABLE) * 16 + b];
				end
			end else if (addr >= `VIP_OFF_PRIO && addr <
				`VIP_REG_AW'(`VIP_OFF_PRIO + `VIP_NUM_PRIO_REGS)) begin
				for (int j = 0; j < `VIP_PER_PRIO_REG; j++) begin
					if (int'(addr - `VIP_OFF_PRIO) * `VIP_PER_PRIO_REG + j
						< `VIP_NUM_IRQ) begin
						rdata[j * 4 +: 3] <=
							priority_field_bank_q[j + `VIP_PER_PRIO_REG
							* int'(addr - `VIP_OFF_PRIO)];
					end
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions.
	blocked_level_a: assert property (@(posedge clk) disable iff (rst)
		(cpu_priority_level == 3'h7 && trap_flag_q == '0) |=> !core_req.req)
		else $error("user request raised at blocked level");
	trap_first_a: assert property (@(posedge clk) disable iff (rst)
		(trap_flag_q != '0 && state_q == vip_pkg::VIP_IDLE && !ack) |=>
		(core_req.req && core_req.level == {1'b1, `VIP_PRIO_BLOCK}
		&& core_req.vec_num < 7'(`VIP_NUM_TRAP)))
		else $error("trap not chosen first");
	alt_addr_a: assert property (@(posedge clk) disable iff (rst)
		(alt_table_select && win.valid && !win.is_trap) |=>
		core_req.vec_addr >= 24'h000114)
		else $error("alternate address below table");
	entry_len_a: assert property (@(posedge clk) disable iff (rst)
		(state_q == vip_pkg::VIP_IDLE && win.valid && ack) |=>
		(state_q == vip_pkg::VIP_ENTRY)[*3] ##1
		state_q == vip_pkg::VIP_SERVICE)
		else $error("entry length wrong");
	return_len_a: assert property (@(posedge clk) disable iff (rst)
		(state_q == vip_pkg::VIP_SERVICE && ret) |=>
		(state_q == vip_pkg::VIP_RETURN)[*3] ##1 state_q == vip_pkg::VIP_IDLE)
		else $error("return length wrong");
	flag_sticky_a: assert property (@(posedge clk) disable iff (rst)
		(request_flag_bank_q[0] && !flag_wr_mask[0]) |=>
		request_flag_bank_q[0])
		else $error("flag dropped without software clear");
	latch_vec_a: assert property (@(posedge clk) disable iff (rst)
		(state_q == vip_pkg::VIP_IDLE && win.valid && ack && !win.is_trap)
		|=> latched_vector_number_q == 7'($past(win.vec_num) + 7'h08))
		else $error("vector number not latched");
	req_cause_a: assert property (@(posedge clk) disable iff (rst)
		core_req.req |-> $past(win.valid))
		else $error("request without a pending source");
	prim_addr_a: assert property (@(posedge clk) disable iff (rst)
		(!alt_table_select && win.valid && !win.is_trap) |=>
		core_req.vec_addr ==
		24'h000014 + {16'h0000, $past(win.vec_num), 1'b0})
		else $error("primary vector address wrong");
	table_bound_a: assert property (@(posedge clk) disable iff (rst)
		core_req.req |-> core_req.vec_addr < `VIP_CODE_START)
		else $error("vector address beyond tables");
	trap_cov: cover property (@(posedge clk) win.valid && win.is_trap && ack);
	irq_cov: cover property (@(posedge clk) win.valid && !win.is_trap && ack);
	alt_cov: cover property (@(posedge clk) alt_table_select && core_req.req);
	ret_cov: cover property (@(posedge clk) state_q == vip_pkg::VIP_RETURN);
endmodule : vip_prioritizer

// File: testbench/vip_core_model.sv
// Core-side model: accepts vectored requests, services them, returns.
`timescale 1ns/1ps
module vip_core_model (
	input  wire logic              clk,      // system clock
	input  wire logic              rst,      // async reset
	input  vip_pkg::vip_core_req_t core_req, // request from the block
	input  wire logic [3:0]        ack_dly,  // wait before accepting
	output logic                   ack,      // accept pulse
	output logic                   ret,      // return pulse
	output vip_pkg::vip_core_req_t taken,    // request seen at accept
	output int                     n_acc     // accepts so far
);
	logic [3:0] cnt;
	logic [3:0] svc;
	// The service time is fixed so the routine always ends well after entry.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			{ack, ret, cnt, svc, taken} <= '0;
			n_acc <= 0;
		end else begin
			ack <= 1'b0;
			ret <= svc == 4'h1;
			svc <= (svc == 4'h0) ? 4'h0 : svc - 4'h1;
			cnt <= core_req.req ? cnt + 4'h1 : 4'h0;
			if (core_req.req && !ack && svc == 4'h0 && cnt >= ack_dly) begin
				ack <= 1'b1;
				taken <= core_req;
				n_acc <= n_acc + 1;
				svc <= 4'hC;
			end
		end
	end
endmodule : vip_core_model

// File: testbench/tb.sv
// Self-checking bench for the vectored interrupt prioritizer.
`timescale 1ns/1ps
module tb;
	logic                   clk, rst, ack, ret, wr, rd, busy;
	logic [117:0]           irq_in;
	logic [7:0]             trap_in, addr;
	logic [2:0]             cpl;
	logic [3:0]             ack_dly;
	logic [15:0]            wdata, rdata, v;
	logic [23:0]            pc_reset;
	vip_pkg::vip_core_req_t core_req, taken;
	int                     n_acc, n_mismatch = 0, samples_checked = 0;
	////////////////////////////////////////////////////////////////////////
	vip_prioritizer uut (.clk(clk), .rst(rst), .irq_in(irq_in),
		.trap_in(trap_in), .cpu_priority_level(cpl), .ack(ack), .ret(ret),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.core_req(core_req), .busy(busy), .pc_reset(pc_reset));
	vip_core_model core (.clk(clk), .rst(rst), .core_req(core_req),
		.ack_dly(ack_dly), .ack(ack), .ret(ret), .taken(taken),
		.n_acc(n_acc));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic final_report();
		$display("Checks %0d, mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : final_report
	task automatic chk(input string what, input logic [23:0] e, g);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	// Read data appear in the cycle after the strobe and hold until the next read.
	task automatic rd_reg(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask : rd_reg
	task automatic pulse(input logic [117:0] m);
		@(posedge clk);
		irq_in <= m;
		@(posedge clk);
		irq_in <= '0;
	endtask : pulse
	task automatic serve(input logic [23:0] a, input logic [6:0] num,
		input logic [3:0] lvl, input logic [7:0] tf);
		int k;
		k = n_acc;
		for (int i = 0; i < 60 && n_acc == k; i++)
			@(posedge clk);
		chk("accept count", 24'(k + 1), 24'(n_acc));
		chk("vector address", a, taken.vec_addr);
		chk("vector number", 24'(num), 24'(taken.vec_num));
		chk("new level", 24'(lvl), 24'(taken.level));
		rd_reg(8'h01);
		chk("status", 24'({1'b0, lvl, num, 4'h0} | 16'(tf)), 24'(v));
	endtask : serve
	task automatic idle();
		for (int i = 0; i < 60 && busy !== 1'b0; i++)
			@(posedge clk);
		chk("busy", 24'h0, 24'(busy));
		repeat (3) @(posedge clk);
		chk("no request", 24'h0, 24'(core_req.req));
	endtask : idle
	task automatic t_reset();
		chk("reset pc", 24'h0, pc_reset);
		rd_reg(8'h00);
		chk("control two", 24'h0, 24'(v));
		rd_reg(8'h30);
		chk("priority reset", 24'h4444, 24'(v));
		rd_reg(8'hFF);
		chk("unmapped read", 24'h0, 24'(v));
	endtask : t_reset
	task automatic t_single(input int n, input logic alt);
		logic [7:0]  r;
		logic [15:0] b;
		r = 8'(n / 16);
		b = 16'h1 << (n % 16);
		wr_reg(8'h00, {alt, 15'h0});
		wr_reg(8'h20 + r, b);
		pulse(118'h1 << n);
		serve(24'h14 + 24'(2 * n) + {15'h0, alt, 8'h0}, 7'(n + 8), 4'h4,
			8'h0);
		rd_reg(8'h10 + r);
		chk("flag held", 24'(b), 24'(v));
		wr_reg(8'h10 + r, 16'h0);
		idle();
	endtask : t_single
	task automatic t_prio();
		wr_reg(8'h31, 16'h4424);
		wr_reg(8'h3A, 16'h4446);
		wr_reg(8'h20, 16'h0620);
		wr_reg(8'h22, 16'h0100);
		pulse((118'h1 << 5) | (118'h1 << 40));
		serve(24'h64, 7'd48, 4'h6, 8'h0);
		wr_reg(8'h10, 16'h0);
		wr_reg(8'h12, 16'h0);
		idle();
		pulse((118'h1 << 9) | (118'h1 << 10));
		serve(24'h26, 7'd17, 4'h4, 8'h0);
		wr_reg(8'h10, 16'h0);
		idle();
	endtask : t_prio
	// Traps are taken slowly here while a user source is held off.
	task automatic t_mask();
		cpl <= 3'h7;
		wr_reg(8'h21, 16'h0010);
		pulse(118'h1 << 20);
		repeat (20) @(posedge clk);
		chk("held off", 24'h0, 24'(core_req.req));
		ack_dly <= 4'h5;
		for (int t = 1; t < 5; t++) begin
			@(posedge clk);
			trap_in <= 8'h1 << t;
			@(posedge clk);
			trap_in <= 8'h00;
			serve(24'h4 + 24'(2 * t), 7'(t), 4'hF, 8'h1 << t);
			wr_reg(8'h01, 16'(8'h1 << t));
			idle();
		end
		ack_dly <= 4'h0;
		cpl <= 3'h4;
		repeat (10) @(posedge clk);
		chk("equal level", 24'h0, 24'(core_req.req));
		cpl <= 3'h3;
		serve(24'h3C, 7'd28, 4'h4, 8'h0);
		wr_reg(8'h11, 16'h0);
		idle();
	endtask : t_mask
	initial begin
		{rst, wr, rd} = 3'b100;
		{irq_in, trap_in, cpl, ack_dly, addr, wdata} = '0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_single(3, 1'b1);
		t_single(0, 1'b0);
		t_single(53, 1'b0);
		t_single(117, 1'b0);
		t_prio();
		t_mask();
		final_report();
	end
	// The tests need under 1500 cycles; the watchdog allows ten times that.
	initial begin
		#150000;
		n_mismatch++;
		final_report();
	end
endmodule : tb
